// ===== hdl/ics_pkg.sv
// Constants and types of the I/O card interrupt status logic
package ics_pkg;
  localparam logic [11:0] OFS_RISE_EN  = 12'h374;
  localparam logic [11:0] OFS_FALL_EN  = 12'h378;
  localparam logic [11:0] OFS_MAIN     = 12'h384;
  localparam logic [11:0] OFS_ERR      = 12'h388;
  localparam logic [11:0] OFS_PIN_STAT = 12'h38C;
  localparam logic [11:0] OFS_GLOBAL   = 12'h398;
  localparam int LINES          = 14;
  localparam int B_PIN_SUM      = 31;
  localparam int B_ERR_SUM      = 30;
  localparam int B_FRAME_TIMER  = 29;
  localparam int B_FRAME_TRIGGER_FLAG   = 28;
  localparam int B_ADC_B_DONE   = 25;
  localparam int B_ADC_A_DONE   = 24;
  localparam int B_DAC_B_DONE   = 17;
  localparam int B_DAC_A_DONE   = 16;
  localparam int B_IN_COUNT     = 12;
  localparam int B_IN_DMA_LO    = 8;
  localparam int B_OUT_COUNT    = 4;
  localparam int B_OUT_DMA_TERM = 0;
  localparam int B_IN_FRAME     = 27;
  localparam int B_IN_OVERRUN   = 26;
  localparam int B_QUEUE_OVF    = 25;
  localparam int B_IN_DMA_ERR   = 24;
  localparam int B_OUT_FRAME    = 19;
  localparam int B_OUT_TIMING   = 18;
  localparam int B_OUT_UNDERRUN = 17;
  localparam int B_OUT_DMA_ERR  = 16;
  localparam int B_DAC_B_ALERT  = 1;
  localparam int B_DAC_A_ALERT  = 0;
  localparam int B_ACK_MODE     = 1;
  localparam logic [31:0] MAIN_CLR_MASK = 32'h3303_1711;
  localparam logic [31:0] ERR_CLR_MASK  = 32'h0F0F_0003;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;

  typedef struct packed {
    logic       frame_timer;
    logic       frame_trigger_flag;
    logic       adc_a_conv_done;
    logic       adc_b_conv_done;
    logic       dac_a_conv_done;
    logic       dac_b_conv_done;
    logic       input_count_reached;
    logic [2:0] input_dma_term;
    logic       output_count_reached;
    logic       output_dma_term;
  } ics_main_ev_t;

  typedef struct packed {
    logic input_frame_fault;
    logic input_overrun_fault;
    logic sample_queue_overflow;
    logic input_dma_fault;
    logic output_frame_fault;
    logic output_timing_fault;
    logic output_underrun_fault;
    logic output_dma_fault;
    logic dac_a_alert_flag;
    logic dac_b_alert_flag;
  } ics_err_ev_t;

  typedef struct packed {
    logic [LINES-1:0] pin_meta;
    logic [LINES-1:0] pin_sync;
    logic [LINES-1:0] pin_prev;
    logic [LINES-1:0] rise_en;
    logic [LINES-1:0] fall_en;
    logic [LINES-1:0] pin_flags;
    logic [31:0]      main_flags;
    logic [31:0]      err_flags;
    logic             ack_by_read_select;
    logic [31:0]      rdata;
    logic             rvalid;
    logic             irq;
  } ics_state_t;
endpackage

// ===== hdl/ics_status.sv
// Interrupt enable and status registers of the I/O card
`timescale 1ns/1ns
`default_nettype none
module ics_status #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [31:0]          reg_wdata,
  output var  logic [31:0]          reg_rdata,
  output var  logic                 reg_rvalid,
  input  wire logic [13:0]          dio_pins,
  input  wire logic                 manual_mode,
  input  wire logic [31:0]          error_irq_en,
  input  wire ics_pkg::ics_main_ev_t main_ev,
  input  wire ics_pkg::ics_err_ev_t  err_ev,
  output var  logic                 irq
);

  ics_pkg::ics_state_t s;
  ics_pkg::ics_state_t next_s;
  logic [31:0] main_set;
  logic [31:0] err_set;
  logic [31:0] main_clr;
  logic [31:0] err_clr;
  logic [13:0] pin_set;
  logic [13:0] pin_clr;
  logic [13:0] fall_hit;
  logic [13:0] rise_hit;
  logic        pin_any;
  logic        err_any;
  logic [31:0] main_view;

  assign fall_hit  = s.pin_prev & ~s.pin_sync & s.fall_en;
  assign rise_hit  = ~s.pin_prev & s.pin_sync & s.rise_en;
  assign pin_any   = |s.pin_flags;
  assign err_any   = |(s.err_flags & error_irq_en);
  always_comb
  begin
    main_view = s.main_flags;
    main_view[ics_pkg::B_PIN_SUM] = pin_any;
    main_view[ics_pkg::B_ERR_SUM] = err_any;
  end

  always_comb
  begin
    main_set = '0;
    main_set[ics_pkg::B_FRAME_TIMER] = main_ev.frame_timer;
    main_set[ics_pkg::B_FRAME_TRIGGER_FLAG]  = main_ev.frame_trigger_flag;
    main_set[ics_pkg::B_ADC_A_DONE]  = manual_mode & main_ev.adc_a_conv_done;
    main_set[ics_pkg::B_ADC_B_DONE]  = FULL_VARIANT & manual_mode & main_ev.adc_b_conv_done;
    main_set[ics_pkg::B_DAC_A_DONE]  = manual_mode & main_ev.dac_a_conv_done;
    main_set[ics_pkg::B_DAC_B_DONE]  = FULL_VARIANT & manual_mode & main_ev.dac_b_conv_done;
    main_set[ics_pkg::B_IN_COUNT]    = main_ev.input_count_reached;
    main_set[ics_pkg::B_IN_DMA_LO +: 3] = main_ev.input_dma_term;
    main_set[ics_pkg::B_OUT_COUNT]   = main_ev.output_count_reached;
    main_set[ics_pkg::B_OUT_DMA_TERM] = main_ev.output_dma_term;
  end

  always_comb
  begin
    err_set = '0;
    err_set[ics_pkg::B_IN_FRAME]     = err_ev.input_frame_fault;
    err_set[ics_pkg::B_IN_OVERRUN]   = err_ev.input_overrun_fault;
    err_set[ics_pkg::B_QUEUE_OVF]    = err_ev.sample_queue_overflow;
    err_set[ics_pkg::B_IN_DMA_ERR]   = err_ev.input_dma_fault;
    err_set[ics_pkg::B_OUT_FRAME]    = err_ev.output_frame_fault;
    err_set[ics_pkg::B_OUT_TIMING]   = err_ev.output_timing_fault;
    err_set[ics_pkg::B_OUT_UNDERRUN] = err_ev.output_underrun_fault;
    err_set[ics_pkg::B_OUT_DMA_ERR]  = err_ev.output_dma_fault;
    err_set[ics_pkg::B_DAC_A_ALERT]  = err_ev.dac_a_alert_flag;
    err_set[ics_pkg::B_DAC_B_ALERT]  = FULL_VARIANT & err_ev.dac_b_alert_flag;
  end

  assign pin_set = fall_hit | rise_hit;

  // Clear masks; read clear takes every bit of the register's clear mask
  always_comb
  begin
    main_clr = '0;
    err_clr  = '0;
    pin_clr  = '0;
    if (reg_wr && !s.ack_by_read_select)
    begin
      if (reg_addr == ics_pkg::OFS_MAIN)
        main_clr = reg_wdata & ics_pkg::MAIN_CLR_MASK;
      if (reg_addr == ics_pkg::OFS_ERR)
        err_clr = reg_wdata & ics_pkg::ERR_CLR_MASK;
      if (reg_addr == ics_pkg::OFS_PIN_STAT)
        pin_clr = reg_wdata[13:0];
    end
    if (reg_rd && s.ack_by_read_select)
    begin
      if (reg_addr == ics_pkg::OFS_MAIN)
        main_clr = ics_pkg::MAIN_CLR_MASK;
      if (reg_addr == ics_pkg::OFS_ERR)
        err_clr = ics_pkg::ERR_CLR_MASK;
      if (reg_addr == ics_pkg::OFS_PIN_STAT)
        pin_clr = '1;
    end
  end

  always_comb
  begin
    next_s = s;
    // Meta stage feeds only the second stage
    next_s.pin_meta = dio_pins;
    next_s.pin_sync = s.pin_meta;
    next_s.pin_prev = s.pin_sync;
    // Set wins so an event in the clearing cycle survives
    next_s.main_flags = (s.main_flags & ~main_clr) | main_set;
    next_s.err_flags  = (s.err_flags & ~err_clr) | err_set;
    next_s.pin_flags  = (s.pin_flags & ~pin_clr) | pin_set;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ics_pkg::OFS_FALL_EN: next_s.fall_en = reg_wdata[13:0];
        ics_pkg::OFS_RISE_EN: next_s.rise_en = reg_wdata[13:0];
        ics_pkg::OFS_GLOBAL:  next_s.ack_by_read_select = reg_wdata[ics_pkg::B_ACK_MODE];
        default: ;
      endcase
    end
    next_s.rvalid = reg_rd;
    next_s.rdata  = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ics_pkg::OFS_FALL_EN:  next_s.rdata = {18'h0_0000, s.fall_en};
        ics_pkg::OFS_RISE_EN:  next_s.rdata = {18'h0_0000, s.rise_en};
        ics_pkg::OFS_MAIN:     next_s.rdata = main_view;
        ics_pkg::OFS_ERR:      next_s.rdata = s.err_flags;
        ics_pkg::OFS_PIN_STAT: next_s.rdata = {18'h0_0000, s.pin_flags};
        ics_pkg::OFS_GLOBAL:   next_s.rdata = {30'h0000_0000, s.ack_by_read_select, 1'b0};
        default:               next_s.rdata = '0;
      endcase
    end
    // Computed from next state so the request has no extra lag
    next_s.irq = (|next_s.main_flags) | (|next_s.pin_flags)
               | (|(next_s.err_flags & error_irq_en));
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign reg_rdata  = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign irq        = s.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_fall_en_reset:
    assert property ($rose(resetn) |-> s.fall_en == 14'h0000)
    else $error("falling enables not cleared by reset");

  a_fall_edge_flag:
    assert property (ce && fall_hit != 14'h0000 && !reg_wr && !reg_rd
                     |=> (s.pin_flags & $past(fall_hit)) == $past(fall_hit))
    else $error("enabled falling edge did not set line flag");

  a_no_edge_quiet:
    assert property (ce && pin_set == 14'h0000 |=> (s.pin_flags & ~$past(s.pin_flags)) == 14'h0000)
    else $error("line flag set without enabled edge");

  a_sync_delay:
    assert property (ce ##1 ce ##1 ce |-> s.pin_sync == $past(dio_pins, 2))
    else $error("pin synchroniser depth wrong");

  a_pin_summary:
    assert property (ce && reg_rd && reg_addr == ics_pkg::OFS_MAIN
                     |=> reg_rvalid && reg_rdata[31] == $past(pin_any))
    else $error("line summary bit wrong");

  a_err_summary:
    assert property (ce && reg_rd && reg_addr == ics_pkg::OFS_MAIN
                     |=> reg_rdata[30] == $past(err_any))
    else $error("error summary bit wrong");

  a_frame_timer:
    assert property (ce && main_ev.frame_timer |=> s.main_flags[29])
    else $error("frame timer flag not set");

  a_manual_gate:
    assert property (ce && !manual_mode && !s.main_flags[24] |=> !s.main_flags[24])
    else $error("conversion done set outside manual mode");

  a_err_fault:
    assert property (ce && err_ev.input_frame_fault |=> s.err_flags[27])
    else $error("input frame fault flag not set");

  a_write_clear:
    assert property (ce && reg_wr && reg_addr == ics_pkg::OFS_MAIN && !s.ack_by_read_select
                     && reg_wdata[29] && !main_ev.frame_timer |=> !s.main_flags[29])
    else $error("write one did not clear flag");

  a_read_clear:
    assert property (ce && reg_rd && reg_addr == ics_pkg::OFS_ERR && s.ack_by_read_select
                     && err_set == 32'h0000_0000 |=> s.err_flags == 32'h0000_0000)
    else $error("read did not clear error flags");

  a_irq_follow:
    assert property ($past(ce) && $stable(error_irq_en) |-> irq == ((|s.main_flags)
                     || (|s.pin_flags) || err_any))
    else $error("interrupt request does not follow flags");

  c_fall_event: cover property (ce && fall_hit != 14'h0000 ##1 irq);
  c_read_clear: cover property (ce && reg_rd && s.ack_by_read_select && s.err_flags != 32'h0000_0000);
  c_set_on_clear: cover property (ce && reg_wr && reg_addr == ics_pkg::OFS_MAIN && main_ev.frame_timer);

endmodule // ics_status
`default_nettype wire

// ===== verif/ics_host.sv
// Host register access model for the interrupt status bench
`timescale 1ns/1ns
`default_nettype none
module ics_host (
  input  wire logic        clk,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [11:0] reg_addr,
  output var  logic [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #5;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #5;
    reg_wr = 1'b0;
    // Stale data never left looking valid
    reg_wdata = ~d;
  endtask

  // Answer is registered, so it stands in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    #5;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #5;
    reg_rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // ics_host
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the I/O card interrupt status logic
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  reg_wr, reg_rd, reg_rvalid, irq, mode;
  logic                  manual_mode = 1'b0;
  logic [11:0]           reg_addr, mv;
  logic [31:0]           reg_wdata, reg_rdata, en, em, ee;
  logic [31:0]           err_en = 32'h0000_0000;
  logic [13:0]           pins = 14'h3FFF;
  logic [9:0]            ev;
  ics_pkg::ics_main_ev_t main_ev = '0;
  ics_pkg::ics_err_ev_t  err_ev = '0;
  int                    mismatches = 0;
  int                    total_checks = 0;

  always #25 clk = ~clk;

  ics_status dut (.clk(clk), .resetn(resetn), .ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .dio_pins(pins), .manual_mode(manual_mode), .error_irq_en(err_en), .main_ev(main_ev),
    .err_ev(err_ev), .irq(irq));
  ics_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  function automatic logic [31:0] exp_main(input logic [11:0] m, input logic man);
    logic [31:0] r;
    r = {2'b00, m[11:10], 2'b00, m[8] & man, m[9] & man, 6'h00, m[6] & man, m[7] & man, 3'h0,
         m[5], 1'b0, m[4:2], 3'h0, m[1], 3'h0, m[0]};
    return r;
  endfunction

  function automatic logic [31:0] exp_err(input logic [9:0] e);
    return {4'h0, e[9:6], 4'h0, e[5:2], 14'h0000, e[0], e[1]};
  endfunction

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic        v;
    host.rd(a, d, v);
    chk(nm, {1'b1, e}, {v, d});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Roughly seven times the expected run length
  initial
  begin
    #(5000 * 50);
    mismatches++;
    results();
  end

  initial
  begin
    void'($urandom(59035));
    repeat (10) @(posedge clk);
    #5 resetn = 1'b1;
    rdchk(ics_pkg::OFS_FALL_EN, 32'h0000_0000, "fall enable reset");
    rdchk(ics_pkg::OFS_MAIN, 32'h0000_0000, "main reset");
    rdchk(ics_pkg::OFS_ERR, 32'h0000_0000, "error reset");
    rdchk(12'h400, 32'h0000_0000, "unmapped read");
    // Lines 1 and 14 enabled, line 2 disabled, rest random
    en = ($urandom() | 32'h0000_2001) & 32'hFFFF_FFFD;
    host.wr(ics_pkg::OFS_FALL_EN, en);
    rdchk(ics_pkg::OFS_FALL_EN, en & 32'h0000_3FFF, "fall enable");
    for (int i = 0; i < 14; i++)
    begin
      pins[i] = 1'b0;
      repeat (6) @(posedge clk);
      rdchk(ics_pkg::OFS_PIN_STAT, en & (32'h0000_0001 << i), "line flag");
      rdchk(ics_pkg::OFS_MAIN, {en[i], 31'h0000_0000}, "line summary");
      chk("line irq", {32'h0000_0000, en[i]}, {32'h0000_0000, irq});
      host.wr(ics_pkg::OFS_PIN_STAT, 32'hFFFF_FFFF);
      pins[i] = 1'b1;
      repeat (6) @(posedge clk);
      rdchk(ics_pkg::OFS_PIN_STAT, 32'h0000_0000, "line flag once");
    end
    // Line 2 has only its rise enable: the fall must be ignored, the rise kept
    host.wr(ics_pkg::OFS_RISE_EN, 32'h0000_0002);
    pins[1] = 1'b0;
    repeat (6) @(posedge clk);
    rdchk(ics_pkg::OFS_PIN_STAT, 32'h0000_0000, "rise only ignores fall");
    pins[1] = 1'b1;
    repeat (6) @(posedge clk);
    rdchk(ics_pkg::OFS_PIN_STAT, 32'h0000_0002, "rise flag");
    host.wr(ics_pkg::OFS_PIN_STAT, 32'h0000_0002);
    rdchk(ics_pkg::OFS_PIN_STAT, 32'h0000_0000, "rise flag cleared");
    for (int i = 0; i < 24; i++)
    begin
      mode = i[0];
      manual_mode = 1'($urandom());
      err_en = $urandom();
      mv = (i < 4) ? 12'hFFF : 12'($urandom());
      ev = (i < 4) ? 10'h3FF : 10'($urandom());
      em = exp_main(mv, manual_mode);
      ee = exp_err(ev);
      host.wr(ics_pkg::OFS_GLOBAL, {30'h0000_0000, mode, 1'b0});
      @(posedge clk);
      #5 main_ev = ics_pkg::ics_main_ev_t'(mv);
      err_ev = ics_pkg::ics_err_ev_t'(ev);
      @(posedge clk);
      #5 main_ev = '0;
      err_ev = '0;
      chk("irq raised", {32'h0000_0000, |em | |(ee & err_en)}, {32'h0000_0000, irq});
      // Ignored while reads do the clearing
      if (mode)
        host.wr(ics_pkg::OFS_MAIN, 32'hFFFF_FFFF);
      rdchk(ics_pkg::OFS_MAIN, em | {1'b0, |(ee & err_en), 30'h0000_0000}, "main flags");
      rdchk(ics_pkg::OFS_ERR, ee, "error flags");
      if (!mode)
      begin
        host.wr(ics_pkg::OFS_MAIN, 32'hFFFF_FFFF);
        host.wr(ics_pkg::OFS_ERR, 32'hFFFF_FFFF);
      end
      rdchk(ics_pkg::OFS_MAIN, 32'h0000_0000, "main cleared");
      rdchk(ics_pkg::OFS_ERR, 32'h0000_0000, "error cleared");
      chk("irq dropped", 33'h0_0000_0000, {32'h0000_0000, irq});
    end
    results();
  end
endmodule // tb
`default_nettype wire
